// ---- logic/tunnel_udp_host.sv ----
`timescale 1ns/100ps
// Behaviour
// [RULE_01] unicast downstream: use node announced port
// [RULE_02] no announced port: node control port
// [RULE_03] multicast port taken from configured range
// [RULE_04] node never assigns multicast range unicast
// [RULE_05] one fixed core source port per session
// [RULE_06] node returns to announced core source
// [RULE_07] else node uses core control port
// [RULE_08] upstream: node sends to core port
// [RULE_09] node keeps fixed upstream source port
// [RULE_10] upstream: send to node source port
// [RULE_11] control tx without auth: compute checksum
// [RULE_12] control rx without auth: drop bad/zero
// [RULE_13] control tx with auth may send zero
// [RULE_14] data tx checksum should be zero
// [RULE_15] zero checksum on rx is skipped
// [RULE_16] ipv6 control tx always carries checksum
// [RULE_17] ipv6 control rx verifies nonzero checksum
// [RULE_18] ipv6 data checksum optional both ways
// [RULE_19] trailing ethernet crc32 supported
// [RULE_20] first request to 1701 from control port
// [RULE_21] node uses udp after udp request
// [RULE_22] computed zero checksum sent as ones
module tunnel_udp_host
   import tunnel_udp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [15:0] s_data,
   input wire logic s_last,
   input wire logic s_rx,
   input wire logic [1:0] s_kind,
   input wire logic [1:0] s_sess,
   output logic res_valid,
   output logic res_drop,
   output logic res_udp,
   output logic [15:0] res_dst_port,
   output logic [15:0] res_src_port,
   output logic [15:0] res_csum,
   output logic [31:0] res_crc
);
   function automatic logic sess_hit(input logic [7:0] a, input logic w);
      sess_hit = (a[7:5] == OFS_SESS_TOP) && (a[SWORD_BIT] == w) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [15:0] pick(input logic v, input logic [15:0] p, input logic [15:0] fb);
      pick = v ? p : fb;
   endfunction

   function automatic logic in_rng(input logic [15:0] p, input logic [15:0] lo, input logic [15:0] hi);
      in_rng = (p >= lo) && (p <= hi);
   endfunction

   eng_if eng ();

   csum_crc_engine u_eng (
      .pclk(pclk),
      .presetn(presetn),
      .e(eng)
   );

   logic [CTRL_W-1:0] ctrl_r;
   logic [15:0] core_ctrl_r, node_ctrl_r, mlo_r, mhi_r;
   logic [15:0] node_port_r [SESS_N];
   logic [15:0] core_src_r [SESS_N];
   logic [15:0] mcast_r [SESS_N];
   logic [1:0] stype_r [SESS_N];
   logic [SESS_N-1:0] en_r, node_v_r, core_v_r;
   logic [2:0] sticky_r;
   logic last_drop_r;
   logic [15:0] tx_cnt_r, drop_cnt_r;
   state_t state_r;
   logic [4:0] cnt_r;
   logic [15:0] field_r;
   logic rx_r;
   logic [1:0] kind_r, sess_r;
   logic hit, wr_en, beat, fin, is_ctrl;
   logic [1:0] aidx;
   logic [31:0] rd_val;
   logic [15:0] cur_np, cur_cs, cur_mc;
   logic [1:0] cur_ty;
   logic cur_nv, cur_cv, cur_en;
   logic [4:0] pseudo_w, crc_start;
   logic [15:0] dst_nxt, src_nxt, csum_calc, csum_nxt;
   logic conflict, out_rng, crc_bad, drop_nxt;

   // register bus
   assign aidx = paddr[SIDX_LO+1:SIDX_LO];
   assign hit = sess_hit(paddr, 1'b0) || sess_hit(paddr, 1'b1) || (paddr == OFS_CTRL) ||
      (paddr == OFS_PORTS) || (paddr == OFS_MRANGE) || (paddr == OFS_STATUS) ||
      (paddr == OFS_COUNT) || (paddr == OFS_CSUM) || (paddr == OFS_CRC);
   assign wr_en = psel && penable && pwrite && hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   always_comb begin
      rd_val = 32'h0;
      if (sess_hit(paddr, 1'b0)) begin
         rd_val = {core_src_r[aidx], node_port_r[aidx]};
      end else if (sess_hit(paddr, 1'b1)) begin
         rd_val = {9'h0, core_v_r[aidx], node_v_r[aidx], en_r[aidx], 2'h0, stype_r[aidx], mcast_r[aidx]};
      end else begin
         case (paddr)
            OFS_CTRL: rd_val = {25'h0, ctrl_r};
            OFS_PORTS: rd_val = {node_ctrl_r, core_ctrl_r};
            OFS_MRANGE: rd_val = {mhi_r, mlo_r};
            OFS_STATUS: rd_val = {27'h0, sticky_r, last_drop_r, state_r != S_IDLE};
            OFS_COUNT: rd_val = {drop_cnt_r, tx_cnt_r};
            OFS_CSUM: rd_val = {16'h0, res_csum};
            OFS_CRC: rd_val = res_crc;
            default: rd_val = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end

   // [RULE_20] control ports, default 1701
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         core_ctrl_r <= CTRL_PORT_RST;
         node_ctrl_r <= CTRL_PORT_RST;
         mlo_r <= MC_LO_RST;
         mhi_r <= MC_HI_RST;
      end else if (wr_en) begin
         case (paddr)
            OFS_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
            OFS_PORTS: begin
               core_ctrl_r <= pwdata[15:0];
               node_ctrl_r <= pwdata[31:16];
            end
            OFS_MRANGE: begin
               mlo_r <= pwdata[15:0];
               mhi_r <= pwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // [RULE_05] source port locked while enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < SESS_N; i++) begin
            node_port_r[i] <= 16'h0;
            core_src_r[i] <= 16'h0;
            mcast_r[i] <= 16'h0;
            stype_r[i] <= ST_UNI;
         end
         en_r <= '0;
         node_v_r <= '0;
         core_v_r <= '0;
      end else if (wr_en && sess_hit(paddr, 1'b0)) begin
         node_port_r[aidx] <= pwdata[15:0];
         if (!en_r[aidx]) begin
            core_src_r[aidx] <= pwdata[31:16];
         end
      end else if (wr_en && sess_hit(paddr, 1'b1)) begin
         mcast_r[aidx] <= pwdata[15:0];
         stype_r[aidx] <= pwdata[SB_TYPE+1:SB_TYPE];
         en_r[aidx] <= pwdata[SB_EN];
         node_v_r[aidx] <= pwdata[SB_NV];
         if (!en_r[aidx]) begin
            core_v_r[aidx] <= pwdata[SB_CV];
         end
      end
   end

   // packet stream
   assign s_ready = (state_r != S_FIN);
   assign beat = s_valid && s_ready;
   assign fin = (state_r == S_FIN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
      end else begin
         case (state_r)
            S_IDLE: if (beat) begin
               state_r <= s_last ? S_FIN : S_RUN;
            end
            S_RUN: if (beat && s_last) begin
               state_r <= S_FIN;
            end
            S_FIN: state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_r <= 1'b0;
         kind_r <= K_INIT;
         sess_r <= 2'h0;
      end else if (state_r == S_IDLE && beat) begin
         rx_r <= s_rx;
         kind_r <= s_kind;
         sess_r <= s_sess;
      end
   end

   assign pseudo_w = ctrl_r[CB_IPV6] ? PSEUDO_V6 : PSEUDO_V4;
   assign crc_start = ctrl_r[CB_UDP] ? pseudo_w + UDP_HDR_WORDS : 5'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 5'h00;
         field_r <= 16'h0;
      end else if (fin) begin
         cnt_r <= 5'h00;
      end else if (beat) begin
         if (cnt_r != 5'h1f) begin
            cnt_r <= cnt_r + 5'h01;
         end
         if (cnt_r == pseudo_w + UDP_CSUM_WORD) begin
            field_r <= s_data;
         end
      end
   end

   assign eng.clr = fin;
   assign eng.add_en = beat;
   // [RULE_19] crc over tunnel frame only
   assign eng.crc_en = beat && ctrl_r[CB_CRC] && (cnt_r >= crc_start);
   assign eng.data = s_data;

   // session context
   assign cur_np = node_port_r[sess_r];
   assign cur_cs = core_src_r[sess_r];
   assign cur_mc = mcast_r[sess_r];
   assign cur_ty = stype_r[sess_r];
   assign cur_nv = node_v_r[sess_r];
   assign cur_cv = core_v_r[sess_r];
   assign cur_en = en_r[sess_r];
   assign is_ctrl = (kind_r != K_DATA);

   always_comb begin
      dst_nxt = node_ctrl_r;
      src_nxt = core_ctrl_r;
      conflict = 1'b0;
      out_rng = 1'b0;
      case (kind_r)
         // [RULE_20] first request port
         K_INIT: dst_nxt = WELL_KNOWN_PORT;
         K_CTRL: dst_nxt = node_ctrl_r;
         default: begin
            // [RULE_05] fixed session source
            src_nxt = pick(cur_cv, cur_cs, core_ctrl_r);
            if (cur_ty == ST_MCAST) begin
               // [RULE_03] port from range
               out_rng = !in_rng(cur_mc, mlo_r, mhi_r);
               dst_nxt = out_rng ? mlo_r : cur_mc;
            end else begin
               // [RULE_04] node port in range refused
               conflict = cur_nv && in_rng(cur_np, mlo_r, mhi_r);
               // [RULE_01] [RULE_02] [RULE_10] announced or control
               dst_nxt = pick(cur_nv && !conflict, cur_np, node_ctrl_r);
            end
         end
      endcase
   end

   // [RULE_22] zero sent as ones
   assign csum_calc = (eng.sum == CSUM_GOOD) ? CSUM_GOOD : ~eng.sum;
   assign crc_bad = rx_r && ctrl_r[CB_CRC] && (eng.crc != CRC_RESIDUE);

   always_comb begin
      csum_nxt = 16'h0;
      drop_nxt = !is_ctrl && !cur_en;
      if (rx_r) begin
         csum_nxt = field_r;
         if (!ctrl_r[CB_UDP]) begin
            drop_nxt = drop_nxt || crc_bad;
         end else if (field_r == 16'h0) begin
            // [RULE_12] [RULE_15] zero checksum handling
            drop_nxt = drop_nxt || crc_bad || (is_ctrl && !ctrl_r[CB_AUTH]);
         end else if (is_ctrl) begin
            // [RULE_12] [RULE_17] verify control checksum
            drop_nxt = drop_nxt || crc_bad || (eng.sum != CSUM_GOOD);
         end else begin
            // [RULE_18] optional data verify
            drop_nxt = drop_nxt || crc_bad || (ctrl_r[CB_DVER] && eng.sum != CSUM_GOOD);
         end
      end else if (ctrl_r[CB_UDP]) begin
         if (is_ctrl) begin
            // [RULE_11] [RULE_13] [RULE_16] control checksum
            if (ctrl_r[CB_IPV6] || !ctrl_r[CB_AUTH] || !ctrl_r[CB_ZAUTH]) begin
               csum_nxt = csum_calc;
            end
         end else if (ctrl_r[CB_IPV6] && ctrl_r[CB_DCSUM]) begin
            // [RULE_18] optional ipv6 data checksum
            csum_nxt = csum_calc;
         end
         // [RULE_14] data checksum otherwise zero
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid <= 1'b0;
         res_drop <= 1'b0;
         res_udp <= 1'b0;
         res_dst_port <= 16'h0;
         res_src_port <= 16'h0;
         res_csum <= 16'h0;
         res_crc <= 32'h0;
      end else begin
         res_valid <= fin;
         if (fin) begin
            res_drop <= drop_nxt;
            res_udp <= ctrl_r[CB_UDP];
            res_dst_port <= dst_nxt;
            res_src_port <= src_nxt;
            res_csum <= csum_nxt;
            res_crc <= rx_r ? eng.crc : ~eng.crc;
         end
      end
   end

   // status and counters, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sticky_r <= 3'h0;
         last_drop_r <= 1'b0;
         tx_cnt_r <= 16'h0;
         drop_cnt_r <= 16'h0;
      end else begin
         sticky_r <= (sticky_r & ~((wr_en && paddr == OFS_STATUS) ? pwdata[4:2] : 3'h0)) |
            (fin ? {crc_bad, out_rng, conflict} : 3'h0);
         if (fin) begin
            last_drop_r <= drop_nxt;
            if (!rx_r) begin
               tx_cnt_r <= tx_cnt_r + 16'h1;
            end
            if (drop_nxt) begin
               drop_cnt_r <= drop_cnt_r + 16'h1;
            end
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_answer;
      beat && s_last |=> ##1 res_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("no result after last word");

   property p_init;
      res_valid && kind_r == K_INIT |-> res_dst_port == WELL_KNOWN_PORT && res_src_port == $past(core_ctrl_r);
   endproperty
   a_init: assert property (p_init) else $error("first request ports wrong"); // [RULE_20]

   property p_uni;
      res_valid && kind_r == K_DATA && $past(cur_ty) == ST_UNI && $past(cur_nv) &&
         !$past(in_rng(cur_np, mlo_r, mhi_r)) |-> res_dst_port == $past(cur_np);
   endproperty
   a_uni: assert property (p_uni) else $error("unicast port not announced one"); // [RULE_01]

   property p_fallback;
      res_valid && kind_r == K_DATA && $past(cur_ty) != ST_MCAST && !$past(cur_nv)
         |-> res_dst_port == $past(node_ctrl_r);
   endproperty
   a_fallback: assert property (p_fallback) else $error("fallback not control port"); // [RULE_02]

   property p_mcast;
      res_valid && kind_r == K_DATA && $past(cur_ty) == ST_MCAST
         |-> res_dst_port >= $past(mlo_r) && res_dst_port <= $past(mhi_r);
   endproperty
   a_mcast: assert property (p_mcast) else $error("multicast port outside range"); // [RULE_03]

   property p_src;
      res_valid && kind_r == K_DATA && $past(cur_cv) |-> res_src_port == $past(cur_cs);
   endproperty
   a_src: assert property (p_src) else $error("session source port changed"); // [RULE_05]

   property p_ctrl_csum;
      res_valid && !rx_r && is_ctrl && res_udp && !$past(ctrl_r[CB_AUTH])
         |-> res_csum != 16'h0 && res_csum == $past(csum_calc);
   endproperty
   a_ctrl_csum: assert property (p_ctrl_csum) else $error("control checksum missing"); // [RULE_11]

   property p_rx_zero;
      fin && rx_r && is_ctrl && ctrl_r[CB_UDP] && field_r == 16'h0 && !ctrl_r[CB_AUTH] |=> res_drop;
   endproperty
   a_rx_zero: assert property (p_rx_zero) else $error("zero control checksum kept"); // [RULE_12]

   property p_data_zero;
      fin && !rx_r && !is_ctrl && !(ctrl_r[CB_IPV6] && ctrl_r[CB_DCSUM]) |=> res_csum == 16'h0;
   endproperty
   a_data_zero: assert property (p_data_zero) else $error("data checksum not zero"); // [RULE_14]

   property p_skip;
      fin && rx_r && !is_ctrl && cur_en && field_r == 16'h0 && !ctrl_r[CB_CRC] |=> !res_drop;
   endproperty
   a_skip: assert property (p_skip) else $error("zero data checksum dropped"); // [RULE_15]

   property p_v6;
      fin && !rx_r && is_ctrl && ctrl_r[CB_UDP] && ctrl_r[CB_IPV6] |=> res_csum != 16'h0;
   endproperty
   a_v6: assert property (p_v6) else $error("ipv6 control checksum zero"); // [RULE_16]

   property p_crc;
      fin && crc_bad |=> res_drop && sticky_r[2];
   endproperty
   a_crc: assert property (p_crc) else $error("bad crc not dropped"); // [RULE_19]

   c_tx_ctrl: cover property (res_valid && !rx_r && kind_r == K_CTRL);
   c_rx_drop: cover property (res_valid && rx_r && res_drop);
   c_mcast: cover property (res_valid && kind_r == K_DATA && cur_ty == ST_MCAST);
   c_init: cover property (res_valid && kind_r == K_INIT);
endmodule

// ---- logic/tunnel_udp_pkg.sv ----
package tunnel_udp_pkg;
   localparam int SESS_N = 4;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PORTS = 8'h04;
   localparam logic [7:0] OFS_MRANGE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_CSUM = 8'h14;
   localparam logic [7:0] OFS_CRC = 8'h18;
   localparam logic [2:0] OFS_SESS_TOP = 3'h2;
   localparam int SIDX_LO = 3;
   localparam int SWORD_BIT = 2;
   localparam int CB_UDP = 0;
   localparam int CB_AUTH = 1;
   localparam int CB_IPV6 = 2;
   localparam int CB_DCSUM = 3;
   localparam int CB_DVER = 4;
   localparam int CB_CRC = 5;
   localparam int CB_ZAUTH = 6;
   localparam int CTRL_W = 7;
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h01;
   localparam int SB_TYPE = 16;
   localparam int SB_EN = 20;
   localparam int SB_NV = 21;
   localparam int SB_CV = 22;
   localparam logic [15:0] WELL_KNOWN_PORT = 16'h06a5;
   localparam logic [15:0] CTRL_PORT_RST = WELL_KNOWN_PORT;
   localparam logic [15:0] MC_LO_RST = 16'hc000;
   localparam logic [15:0] MC_HI_RST = 16'hc0ff;
   localparam logic [1:0] ST_UNI = 2'h0;
   localparam logic [1:0] ST_MCAST = 2'h1;
   localparam logic [1:0] ST_UP = 2'h2;
   localparam logic [1:0] K_INIT = 2'h0;
   localparam logic [1:0] K_CTRL = 2'h1;
   localparam logic [1:0] K_DATA = 2'h2;
   localparam logic [4:0] PSEUDO_V4 = 5'h06;
   localparam logic [4:0] PSEUDO_V6 = 5'h14;
   localparam logic [4:0] UDP_CSUM_WORD = 5'h03;
   localparam logic [4:0] UDP_HDR_WORDS = 5'h04;
   localparam logic [15:0] CSUM_INIT = 16'h0000;
   localparam logic [15:0] CSUM_GOOD = 16'hffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

   typedef enum logic [1:0] {S_IDLE, S_RUN, S_FIN} state_t;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] x;
      x = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      crc_byte = x;
   endfunction
endpackage

// ---- logic/eng_if.sv ----
`timescale 1ns/100ps
interface eng_if;
   import tunnel_udp_pkg::*;
   logic clr;
   logic add_en;
   logic crc_en;
   logic [15:0] data;
   logic [15:0] sum;
   logic [31:0] crc;
   modport ctl (output clr, add_en, crc_en, data, input sum, crc);
   modport eng (input clr, add_en, crc_en, data, output sum, crc);
endinterface

// ---- logic/csum_crc_engine.sv ----
`timescale 1ns/100ps
module csum_crc_engine
   import tunnel_udp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   eng_if.eng e
);
   logic [15:0] sum_r;
   logic [31:0] crc_r;
   logic [16:0] add_w;

   assign add_w = {1'b0, sum_r} + {1'b0, e.data};
   assign e.sum = sum_r;
   assign e.crc = crc_r;

   // [RULE_22] end-around carry sum
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_r <= CSUM_INIT;
      end else if (e.clr) begin
         sum_r <= CSUM_INIT;
      end else if (e.add_en) begin
         sum_r <= add_w[15:0] + {15'h0, add_w[16]};
      end
   end

   // [RULE_19] ethernet crc, high byte first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_r <= CRC_INIT;
      end else if (e.clr) begin
         crc_r <= CRC_INIT;
      end else if (e.crc_en) begin
         crc_r <= crc_byte(crc_byte(crc_r, e.data[15:8]), e.data[7:0]);
      end
   end
endmodule

// ---- test/node_model.sv ----
`timescale 1ns/100ps
module node_model
   import tunnel_udp_pkg::*;
(
   input wire logic pclk,
   input wire logic s_ready,
   output logic s_valid,
   output logic [15:0] s_data,
   output logic s_last,
   output logic s_rx,
   output logic [1:0] s_kind,
   output logic [1:0] s_sess
);
   logic [15:0] pk [0:39];
   initial begin
      {s_valid, s_data, s_last, s_rx, s_kind, s_sess} = '0;
   end
   function automatic logic [15:0] osum(input int n);
      logic [31:0] a;
      a = 32'h0;
      for (int i = 0; i < n; i++) begin
         a = a + {16'h0, pk[i]};
      end
      a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
      a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
      osum = (a[15:0] == 16'hffff) ? 16'hffff : ~a[15:0];
   endfunction
   function automatic logic [31:0] crc(input int a, input int b);
      logic [31:0] c;
      logic [7:0] y;
      c = CRC_INIT;
      for (int i = 2 * a; i < 2 * b; i++) begin
         y = i[0] ? pk[i / 2][7:0] : pk[i / 2][15:8];
         for (int j = 0; j < 8; j++) begin
            c = (c[0] ^ y[j]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
         end
      end
      crc = c;
   endfunction
   // word stream, held until taken, optional idle gaps
   task automatic send(input int n, input logic rx, input logic [1:0] k, input logic [1:0] sn, input logic slow);
      @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         s_valid <= 1'b1;
         s_data <= pk[i];
         s_last <= (i == n - 1);
         {s_rx, s_kind, s_sess} <= {rx, k, sn};
         @(posedge pclk iff s_ready === 1'b1);
         if (slow && i < n - 1) begin
            s_valid <= 1'b0;
            s_data <= ~pk[i];
            @(posedge pclk);
         end
      end
      s_valid <= 1'b0;
      s_last <= 1'b0;
      s_data <= ~pk[n - 1];
   endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench
   import tunnel_udp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, fcs;
   logic s_valid, s_ready, s_last, s_rx, res_valid, res_drop, res_udp;
   logic [15:0] s_data, res_dst_port, res_src_port, res_csum, nc, cc, np, cs, sc;
   logic [1:0] s_kind, s_sess;
   logic [31:0] res_crc;
   logic [6:0] ct;
   logic [31:0] w0 [4], w1 [4];
   logic [15:0] xd [4], xs [4];
   int miscompares, cmp_count, ps;
   always #12.5 pclk = ~pclk;
   tunnel_udp_host i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data), .s_last(s_last), .s_rx(s_rx),
      .s_kind(s_kind), .s_sess(s_sess), .res_valid(res_valid), .res_drop(res_drop), .res_udp(res_udp),
      .res_dst_port(res_dst_port), .res_src_port(res_src_port), .res_csum(res_csum), .res_crc(res_crc));
   node_model i_node (.pclk(pclk), .s_ready(s_ready), .s_valid(s_valid), .s_data(s_data), .s_last(s_last),
      .s_rx(s_rx), .s_kind(s_kind), .s_sess(s_sess));
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic chk16(input string nm, input logic [15:0] x, input logic [15:0] g);
      chk(nm, {16'h0, x}, {16'h0, g});
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      {penable, pwrite, paddr, pwdata} <= {1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic build(input int p, input logic [15:0] sp, input logic [15:0] dp);
      for (int i = 0; i < p + 8; i++) begin
         i_node.pk[i] = 16'($urandom);
      end
      i_node.pk[p] = sp;
      i_node.pk[p + 1] = dp;
      i_node.pk[p + 3] = 16'h0000;
   endtask
   task automatic run(input int n, input logic rx, input logic [1:0] k, input logic [1:0] sn);
      i_node.send(n, rx, k, sn, 1'($urandom_range(1, 0)));
      @(posedge pclk iff res_valid === 1'b1);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (8000) @(posedge pclk);
      miscompares++;
      print_verdict();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      miscompares = 0;
      cmp_count = 0;
      void'($urandom(8));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h00000001, q);
      apb(1'b0, OFS_PORTS, 32'h0);
      chk("ports reset", 32'h06a506a5, q);
      apb(1'b0, OFS_MRANGE, 32'h0);
      chk("mrange reset", 32'hc0ffc000, q);
      apb(1'b0, 8'h3c, 32'h0);
      chk16("unmapped err", 16'h1, 16'(e));
      nc = 16'h2000 + 16'($urandom_range(4095, 0));
      cc = 16'h3000 + 16'($urandom_range(4095, 0));
      np = 16'h4000 + 16'($urandom_range(4095, 0));
      cs = 16'h5000 + 16'($urandom_range(4095, 0));
      apb(1'b1, OFS_PORTS, {nc, cc});
      // control transmit in each checksum mode
      for (int m = 0; m < 4; m++) begin
         ct = (m < 2) ? 7'h01 : ((m == 2) ? 7'h43 : 7'h47);
         ps = (m == 3) ? 20 : 6;
         apb(1'b1, OFS_CTRL, {25'h0, ct});
         build(ps, cc, (m == 0) ? WELL_KNOWN_PORT : nc);
         run(ps + 8, 1'b0, (m == 0) ? K_INIT : K_CTRL, 2'h0);
         chk16("ctrl dst", (m == 0) ? WELL_KNOWN_PORT : nc, res_dst_port);
         chk16("ctrl src", cc, res_src_port);
         chk16("ctrl csum", (m == 2) ? 16'h0 : i_node.osum(ps + 8), res_csum);
         chk16("udp", 16'h1, 16'(res_udp));
      end
      w0 = '{{cs, np}, {16'h0, 16'hc080}, 32'h0, {cs, np}};
      w1 = '{32'h00700000, 32'h00300000, 32'h0011c010, 32'h00720000};
      xd = '{np, nc, 16'hc010, np};
      xs = '{cs, cc, cc, cs};
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 8'h40 + 8'(8 * s), w0[s]);
         apb(1'b1, 8'h44 + 8'(8 * s), w1[s]);
      end
      for (int r = 0; r < 8; r++) begin
         build(6, xs[r % 4], xd[r % 4]);
         run(14, 1'b0, K_DATA, 2'(r % 4));
         chk16("data dst", xd[r % 4], res_dst_port);
         chk16("data src", xs[r % 4], res_src_port);
         chk16("data csum", 16'h0, res_csum);
      end
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("range flag", 32'h4, q & 32'h4);
      apb(1'b1, OFS_STATUS, 32'h4);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("range flag clear", 32'h0, q & 32'h4);
      apb(1'b1, OFS_CTRL, 32'h00000001);
      // good, zero and corrupt received control checksums
      for (int h = 0; h < 3; h++) begin
         // node control port to core control port
         build(6, nc, cc);
         sc = i_node.osum(14);
         i_node.pk[9] = (h == 0) ? sc : ((h == 1) ? 16'h0 : sc ^ 16'h0001);
         run(14, 1'b1, K_CTRL, 2'h0);
         chk16("ctrl rx drop", 16'(h != 0), 16'(res_drop));
         chk16("ctrl rx field", i_node.pk[9], res_csum);
      end
      apb(1'b1, OFS_CTRL, 32'h00000031);
      // node returns to the announced core source port
      build(6, np, cs);
      fcs = ~i_node.crc(10, 14);
      i_node.pk[14] = {fcs[7:0], fcs[15:8]};
      i_node.pk[15] = {fcs[23:16], fcs[31:24]};
      run(16, 1'b1, K_DATA, 2'h0);
      chk16("data rx drop", 16'h0, 16'(res_drop));
      chk("rx crc", CRC_RESIDUE, res_crc);
      // upstream session: node sends to announced core port
      run(16, 1'b1, K_DATA, 2'h3);
      chk16("up rx drop", 16'h0, 16'(res_drop));
      chk16("up reply dst", np, res_dst_port);
      chk16("up core port", cs, res_src_port);
      i_node.pk[11] = ~i_node.pk[11];
      run(16, 1'b1, K_DATA, 2'h0);
      chk16("crc bad drop", 16'h1, 16'(res_drop));
      // good crc, nonzero wrong data checksum with verify on
      i_node.pk[11] = ~i_node.pk[11];
      i_node.pk[9] = i_node.osum(16) ^ 16'h0001;
      run(16, 1'b1, K_DATA, 2'h0);
      chk16("data verify drop", 16'h1, 16'(res_drop));
      build(6, cs, np);
      run(14, 1'b0, K_DATA, 2'h0);
      chk("tx crc", ~i_node.crc(10, 14), res_crc);
      // ipv6 data with checksum insertion on
      apb(1'b1, OFS_CTRL, 32'h0000000d);
      build(20, cs, np);
      run(28, 1'b0, K_DATA, 2'h0);
      chk16("v6 data csum", i_node.osum(28), res_csum);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("counts", 32'h0004000e, q);
      print_verdict();
   end
endmodule
